/* core/tsp_defines.svh */
// Offsets, field positions, reset value and read-zero value of the pin mux.
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

`define TSP_ADDR_W 8
`define TSP_DATA_W 8

`define TSP_OFF_ANTENNA_CTRL 8'h00
`define TSP_OFF_DIVERSITY_CTRL 8'h01
`define TSP_OFF_TX_RAMP_CTRL 8'h02
`define TSP_OFF_PIN_OVERRIDE 8'h03
`define TSP_OFF_PIN_DRIVE_ENABLE 8'h04
`define TSP_OFF_PIN_FUNCTION 8'h05
`define TSP_OFF_LINK_LOCK_CFG 8'h06

`define TSP_BIT_ANT_REG_SELECT 3
`define TSP_BIT_ANT_REG_VALUE 4
`define TSP_BIT_ANT_REG_VALUE_RD 5
`define TSP_BIT_DIVERSITY_EN 7
`define TSP_BIT_CMD_BIT 0
`define TSP_BIT_RAMP_CTRL_EN 3
`define TSP_BIT_LINK_LOCK 4
`define TSP_BIT_DATA_OVR 0
`define TSP_BIT_ANT_OVR 1
`define TSP_BIT_CMD_OVR 2
`define TSP_BIT_CMD_SHARED 5
`define TSP_BIT_DATA_SHARED 6
`define TSP_BIT_ANT_SHARED 7
`define TSP_BIT_LINK_LOCK_EN 6

`define TSP_RST_REG 8'h00
`define TSP_RD_ZERO 8'h00

`endif

/* core/tsp_pkg.sv */
// Types shared by the pin mux top and its per-pin cell.
package tsp_pkg;

    typedef logic [7:0] tsp_byte_t;

    // Software view of one shared pin.
    typedef struct packed {
        logic func_sel;
        logic drive_en;
        logic ovr_bit;
    } tsp_cell_cfg_s;

endpackage

/* core/tsp_pin_cell.sv */
// One shared transceiver pin: direction, output value and level sampling.
`timescale 1ns/100ps
module tsp_pin_cell
    import tsp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Selection
    input wire logic card_mode,
    input wire logic use_int,
    input wire logic int_val,
    input wire tsp_pkg::tsp_cell_cfg_s cfg,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_level
);
    import tsp_pkg::*;

    logic nxt_oe;
    logic nxt_out;
    logic pin_out_ff;
    logic pin_oe_ff;
    logic pin_level_ff;

    // Address mode leaves the pin as an input whatever software asks for.
    assign nxt_oe = card_mode & (use_int | cfg.drive_en);
    assign nxt_out = nxt_oe & (use_int ? int_val : cfg.ovr_bit);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_oe_ff <= 1'b0;
            pin_out_ff <= 1'b0;
            pin_level_ff <= 1'b0;
        end
        else
        begin
            pin_oe_ff <= nxt_oe;
            pin_out_ff <= nxt_out;
            pin_level_ff <= pin_in;
        end
    end

    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign pin_level = pin_level_ff;

endmodule

/* core/tsp_pin_mux.sv */
// Transceiver pin mux: dedicated antenna pin, four shared pins, registers.
`timescale 1ns/100ps
`include "tsp_defines.svh"
module tsp_pin_mux
    import tsp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Register port
    input wire logic [`TSP_ADDR_W-1:0] reg_addr,
    input wire tsp_pkg::tsp_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output tsp_pkg::tsp_byte_t reg_rdata,
    // Bus-mode strap, high for card mode
    input wire logic bus_mode_card,
    // Internal transmit and diversity logic
    input wire logic tx_active,
    input wire logic tx_timing_active,
    input wire logic ramp_timing_first,
    input wire logic tx_serial_data,
    input wire logic diversity_antenna_choice,
    // Dedicated antenna pin
    output logic antenna_select_out,
    // Shared antenna pin
    input wire logic ant_pin_in,
    output logic ant_pin_out,
    output logic ant_pin_oe,
    // Shared transmit-command pin
    input wire logic cmd_pin_in,
    output logic cmd_pin_out,
    output logic cmd_pin_oe,
    // Shared transmit-data pin
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe,
    // Shared link-lock pin
    input wire logic lock_pin_in,
    output logic lock_pin_out,
    output logic lock_pin_oe,
    // Address bits seen on the shared pins in address mode
    output logic isa_addr_bit_23,
    output logic isa_addr_bit_21,
    output logic isa_addr_bit_20,
    output logic isa_addr_bit_15
);
    import tsp_pkg::*;

    tsp_byte_t antenna_ctrl_reg_ff;
    tsp_byte_t diversity_ctrl_reg_ff;
    tsp_byte_t tx_ramp_ctrl_reg_ff;
    tsp_byte_t pin_override_reg_ff;
    tsp_byte_t pin_drive_enable_reg_ff;
    tsp_byte_t pin_function_reg_ff;
    tsp_byte_t link_lock_cfg_reg_ff;
    tsp_byte_t reg_rdata_ff;
    tsp_byte_t nxt_rdata;
    logic antenna_select_out_ff;
    logic nxt_antenna_select;

    logic antenna_reg_select_enable;
    logic antenna_reg_value;
    logic diversity_enable;
    logic command_bit;
    logic ramp_reg_control_enable;
    logic link_lock_bit;
    logic link_lock_drive_enable;
    tsp_cell_cfg_s ant_cfg;
    tsp_cell_cfg_s cmd_cfg;
    tsp_cell_cfg_s data_cfg;
    tsp_cell_cfg_s lock_cfg;
    logic ant_use_int;
    logic ant_int_val;
    logic cmd_use_int;
    logic cmd_int_val;
    logic ant_level;
    logic cmd_level;
    logic data_level;
    logic lock_level;

    function automatic logic hit(input logic [`TSP_ADDR_W-1:0] off);
        hit = (reg_addr == off);
    endfunction

    assign antenna_reg_select_enable =
        antenna_ctrl_reg_ff[`TSP_BIT_ANT_REG_SELECT];
    assign antenna_reg_value = antenna_ctrl_reg_ff[`TSP_BIT_ANT_REG_VALUE];
    assign diversity_enable = diversity_ctrl_reg_ff[`TSP_BIT_DIVERSITY_EN];
    assign command_bit = tx_ramp_ctrl_reg_ff[`TSP_BIT_CMD_BIT];
    assign ramp_reg_control_enable =
        tx_ramp_ctrl_reg_ff[`TSP_BIT_RAMP_CTRL_EN];
    assign link_lock_bit = tx_ramp_ctrl_reg_ff[`TSP_BIT_LINK_LOCK];
    assign link_lock_drive_enable =
        link_lock_cfg_reg_ff[`TSP_BIT_LINK_LOCK_EN];

    assign ant_cfg = '{func_sel: pin_function_reg_ff[`TSP_BIT_ANT_SHARED],
        drive_en: pin_drive_enable_reg_ff[`TSP_BIT_ANT_SHARED],
        ovr_bit: pin_override_reg_ff[`TSP_BIT_ANT_OVR]};
    // The command override only counts once ramp control is on.
    assign cmd_cfg = '{func_sel: pin_function_reg_ff[`TSP_BIT_CMD_SHARED],
        drive_en: pin_drive_enable_reg_ff[`TSP_BIT_CMD_SHARED],
        ovr_bit: pin_override_reg_ff[`TSP_BIT_CMD_OVR]};
    assign data_cfg = '{func_sel: pin_function_reg_ff[`TSP_BIT_DATA_SHARED],
        drive_en: pin_drive_enable_reg_ff[`TSP_BIT_DATA_SHARED],
        ovr_bit: pin_override_reg_ff[`TSP_BIT_DATA_OVR]};
    assign lock_cfg = '{func_sel: 1'b1, drive_en: link_lock_drive_enable,
        ovr_bit: link_lock_bit};

    // Transmit wins over everything on the dedicated pin.
    assign nxt_antenna_select = !tx_active & (diversity_enable ?
        diversity_antenna_choice :
        (antenna_reg_select_enable & antenna_reg_value));

    assign ant_use_int = !ant_cfg.func_sel;
    assign ant_int_val = antenna_reg_select_enable ? antenna_reg_value :
        diversity_antenna_choice;
    assign cmd_use_int = !ramp_reg_control_enable | !cmd_cfg.func_sel;
    assign cmd_int_val = ramp_reg_control_enable ?
        (command_bit | ramp_timing_first) : tx_timing_active;

    // Each cell registers its drive; the strap gates every driver.
    tsp_pin_cell u_ant_cell
    (
        .clock(clock),
        .arst_n(arst_n),
        .card_mode(bus_mode_card),
        .use_int(ant_use_int),
        .int_val(ant_int_val),
        .cfg(ant_cfg),
        .pin_in(ant_pin_in),
        .pin_out(ant_pin_out),
        .pin_oe(ant_pin_oe),
        .pin_level(ant_level)
    );

    tsp_pin_cell u_cmd_cell
    (
        .clock(clock),
        .arst_n(arst_n),
        .card_mode(bus_mode_card),
        .use_int(cmd_use_int),
        .int_val(cmd_int_val),
        .cfg(cmd_cfg),
        .pin_in(cmd_pin_in),
        .pin_out(cmd_pin_out),
        .pin_oe(cmd_pin_oe),
        .pin_level(cmd_level)
    );

    tsp_pin_cell u_data_cell
    (
        .clock(clock),
        .arst_n(arst_n),
        .card_mode(bus_mode_card),
        .use_int(!data_cfg.func_sel),
        .int_val(!tx_serial_data),
        .cfg(data_cfg),
        .pin_in(data_pin_in),
        .pin_out(data_pin_out),
        .pin_oe(data_pin_oe),
        .pin_level(data_level)
    );

    tsp_pin_cell u_lock_cell
    (
        .clock(clock),
        .arst_n(arst_n),
        .card_mode(bus_mode_card),
        .use_int(1'b0),
        .int_val(1'b0),
        .cfg(lock_cfg),
        .pin_in(lock_pin_in),
        .pin_out(lock_pin_out),
        .pin_oe(lock_pin_oe),
        .pin_level(lock_level)
    );

    // Override and link-lock readback use the sampled pin levels, not the stored bits.
    assign nxt_rdata =
        hit(`TSP_OFF_ANTENNA_CTRL) ?
            {2'b00, antenna_reg_value, 1'b0,
             antenna_reg_select_enable, 3'b000} :
        hit(`TSP_OFF_DIVERSITY_CTRL) ? {diversity_enable, 7'b000_0000} :
        hit(`TSP_OFF_TX_RAMP_CTRL) ?
            {3'b000, lock_level, ramp_reg_control_enable, 2'b00,
             command_bit} :
        hit(`TSP_OFF_PIN_OVERRIDE) ?
            {5'b0_0000, cmd_level, ant_level, data_level} :
        hit(`TSP_OFF_PIN_DRIVE_ENABLE) ?
            {pin_drive_enable_reg_ff[7:5], 5'b0_0000} :
        hit(`TSP_OFF_PIN_FUNCTION) ?
            {pin_function_reg_ff[7:5], 5'b0_0000} :
        hit(`TSP_OFF_LINK_LOCK_CFG) ?
            {1'b0, link_lock_drive_enable, 6'b00_0000} :
        `TSP_RD_ZERO;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            antenna_ctrl_reg_ff <= `TSP_RST_REG;
            diversity_ctrl_reg_ff <= `TSP_RST_REG;
            tx_ramp_ctrl_reg_ff <= `TSP_RST_REG;
            pin_override_reg_ff <= `TSP_RST_REG;
            pin_drive_enable_reg_ff <= `TSP_RST_REG;
            pin_function_reg_ff <= `TSP_RST_REG;
            link_lock_cfg_reg_ff <= `TSP_RST_REG;
        end
        else if (reg_wr)
        begin
            if (hit(`TSP_OFF_ANTENNA_CTRL))
                antenna_ctrl_reg_ff <= reg_wdata;
            if (hit(`TSP_OFF_DIVERSITY_CTRL))
                diversity_ctrl_reg_ff <= reg_wdata;
            if (hit(`TSP_OFF_TX_RAMP_CTRL))
                tx_ramp_ctrl_reg_ff <= reg_wdata;
            if (hit(`TSP_OFF_PIN_OVERRIDE))
                pin_override_reg_ff <= reg_wdata;
            if (hit(`TSP_OFF_PIN_DRIVE_ENABLE))
                pin_drive_enable_reg_ff <= reg_wdata;
            if (hit(`TSP_OFF_PIN_FUNCTION))
                pin_function_reg_ff <= reg_wdata;
            if (hit(`TSP_OFF_LINK_LOCK_CFG))
                link_lock_cfg_reg_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata_ff <= `TSP_RD_ZERO;
            antenna_select_out_ff <= 1'b0;
        end
        else
        begin
            reg_rdata_ff <= reg_rd ? nxt_rdata : `TSP_RD_ZERO;
            antenna_select_out_ff <= nxt_antenna_select;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign antenna_select_out = antenna_select_out_ff;
    assign isa_addr_bit_23 = ant_level;
    assign isa_addr_bit_21 = cmd_level;
    assign isa_addr_bit_20 = data_level;
    assign isa_addr_bit_15 = lock_level;

    property p_ant_tx_low;
        @(posedge clock) disable iff (!arst_n)
        tx_active |=> !antenna_select_out;
    endproperty
    a_ant_tx_low: assert property (p_ant_tx_low)
        else $error("Dedicated antenna pin high during transmit.");

    property p_ant_reg_value;
        @(posedge clock) disable iff (!arst_n)
        (!tx_active && !diversity_enable) |=>
            antenna_select_out == $past(antenna_reg_select_enable &
            antenna_reg_value);
    endproperty
    a_ant_reg_value: assert property (p_ant_reg_value)
        else $error("Dedicated antenna pin ignores register control.");

    property p_ant_diversity;
        @(posedge clock) disable iff (!arst_n)
        (!tx_active && diversity_enable) |=>
            antenna_select_out == $past(diversity_antenna_choice);
    endproperty
    a_ant_diversity: assert property (p_ant_diversity)
        else $error("Dedicated antenna pin ignores diversity choice.");

    property p_addr_mode_inputs;
        @(posedge clock) disable iff (!arst_n)
        !bus_mode_card |=>
            !(ant_pin_oe || cmd_pin_oe || data_pin_oe || lock_pin_oe);
    endproperty
    a_addr_mode_inputs: assert property (p_addr_mode_inputs)
        else $error("Shared pin driven in address mode.");

    property p_ant_shared_int;
        @(posedge clock) disable iff (!arst_n)
        (bus_mode_card && !ant_cfg.func_sel) |=>
            ant_pin_oe && ant_pin_out == $past(ant_int_val);
    endproperty
    a_ant_shared_int: assert property (p_ant_shared_int)
        else $error("Shared antenna pin not driven from antenna source.");

    property p_ant_shared_ovr;
        @(posedge clock) disable iff (!arst_n)
        (bus_mode_card && ant_cfg.func_sel) |=>
            ant_pin_oe == $past(ant_cfg.drive_en) &&
            (!ant_pin_oe || ant_pin_out == $past(ant_cfg.ovr_bit));
    endproperty
    a_ant_shared_ovr: assert property (p_ant_shared_ovr)
        else $error("Shared antenna override misbehaves.");

    property p_ant_readback;
        @(posedge clock) disable iff (!arst_n)
        (reg_rd && reg_addr == `TSP_OFF_PIN_OVERRIDE) |=>
            reg_rdata[`TSP_BIT_ANT_OVR] == $past(ant_pin_in, 2) &&
            reg_rdata[`TSP_BIT_CMD_OVR] == $past(cmd_pin_in, 2) &&
            reg_rdata[`TSP_BIT_DATA_OVR] == $past(data_pin_in, 2);
    endproperty
    a_ant_readback: assert property (p_ant_readback)
        else $error("Override readback differs from pin levels.");

    property p_cmd_int;
        @(posedge clock) disable iff (!arst_n)
        (bus_mode_card && cmd_use_int) |=> cmd_pin_oe &&
            cmd_pin_out == $past(ramp_reg_control_enable ?
            (command_bit | ramp_timing_first) : tx_timing_active);
    endproperty
    a_cmd_int: assert property (p_cmd_int)
        else $error("Command pin not driven from timing source.");

    property p_cmd_ovr;
        @(posedge clock) disable iff (!arst_n)
        (bus_mode_card && ramp_reg_control_enable && cmd_cfg.func_sel) |=>
            cmd_pin_oe == $past(cmd_cfg.drive_en) &&
            (!cmd_pin_oe || cmd_pin_out == $past(cmd_cfg.ovr_bit));
    endproperty
    a_cmd_ovr: assert property (p_cmd_ovr)
        else $error("Command override misbehaves.");

    property p_data_pin;
        @(posedge clock) disable iff (!arst_n)
        bus_mode_card |=> data_pin_oe == $past(!data_cfg.func_sel ||
            data_cfg.drive_en) && (!data_pin_oe || data_pin_out ==
            $past(data_cfg.func_sel ? data_cfg.ovr_bit : !tx_serial_data));
    endproperty
    a_data_pin: assert property (p_data_pin)
        else $error("Data pin drive wrong.");

    property p_lock_pin;
        @(posedge clock) disable iff (!arst_n)
        bus_mode_card |=> lock_pin_oe == $past(link_lock_drive_enable) &&
            (!lock_pin_oe || lock_pin_out == $past(link_lock_bit));
    endproperty
    a_lock_pin: assert property (p_lock_pin)
        else $error("Link-lock pin drive wrong.");

    property p_lock_readback;
        @(posedge clock) disable iff (!arst_n)
        (reg_rd && reg_addr == `TSP_OFF_TX_RAMP_CTRL) |=>
            reg_rdata[`TSP_BIT_LINK_LOCK] == $past(lock_pin_in, 2);
    endproperty
    a_lock_readback: assert property (p_lock_readback)
        else $error("Link-lock readback differs from pin level.");

endmodule

/* tb/tsp_xcvr_model.sv */
// Transceiver-side model that resolves the four shared pin levels.
`timescale 1ns/100ps
module tsp_xcvr_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Device side of the shared pins
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe,
    // Levels the transceiver puts out while it drives
    input wire logic [3:0] ext_val,
    input wire logic [3:0] ext_en,
    // Resolved pin levels
    output logic [3:0] pin_lvl
);
    logic [3:0] float_ff;

    // A pin nobody drives has no pull, so it wanders instead of holding.
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            float_ff <= 4'h5;
        else
            float_ff <= ~float_ff;
    end

    // Two drivers that disagree give an unknown, which no check accepts.
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            if (dev_oe[k] && ext_en[k] && dev_out[k] !== ext_val[k])
                pin_lvl[k] = 1'bx;
            else if (dev_oe[k])
                pin_lvl[k] = dev_out[k];
            else if (ext_en[k])
                pin_lvl[k] = ext_val[k];
            else
                pin_lvl[k] = float_ff[k];
        end
    end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the transceiver pin mux.
`timescale 1ns/100ps
`include "tsp_defines.svh"
module tb_top;
    import tsp_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [`TSP_ADDR_W-1:0] reg_addr = 8'h00;
    tsp_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    tsp_byte_t reg_rdata;
    logic bus_mode_card = 1'b1;
    logic tx_active = 1'b0;
    logic tx_timing_active = 1'b0;
    logic ramp_timing_first = 1'b0;
    logic tx_serial_data = 1'b0;
    logic diversity_antenna_choice = 1'b0;
    logic antenna_select_out;
    logic [3:0] p_out;
    logic [3:0] p_oe;
    logic [3:0] p_lvl;
    logic [3:0] isa;
    logic [3:0] ext_val = 4'h0;
    // Only the link-lock pin is an input after reset; the others are driven.
    logic [3:0] ext_en = 4'h8;
    int err_total = 0;
    int samples_checked = 0;
    tsp_byte_t rdv;

    always #50 clock = ~clock;

    tsp_pin_mux dut
    (
        .clock(clock),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .bus_mode_card(bus_mode_card),
        .tx_active(tx_active),
        .tx_timing_active(tx_timing_active),
        .ramp_timing_first(ramp_timing_first),
        .tx_serial_data(tx_serial_data),
        .diversity_antenna_choice(diversity_antenna_choice),
        .antenna_select_out(antenna_select_out),
        .ant_pin_in(p_lvl[0]),
        .ant_pin_out(p_out[0]),
        .ant_pin_oe(p_oe[0]),
        .cmd_pin_in(p_lvl[1]),
        .cmd_pin_out(p_out[1]),
        .cmd_pin_oe(p_oe[1]),
        .data_pin_in(p_lvl[2]),
        .data_pin_out(p_out[2]),
        .data_pin_oe(p_oe[2]),
        .lock_pin_in(p_lvl[3]),
        .lock_pin_out(p_out[3]),
        .lock_pin_oe(p_oe[3]),
        .isa_addr_bit_23(isa[0]),
        .isa_addr_bit_21(isa[1]),
        .isa_addr_bit_20(isa[2]),
        .isa_addr_bit_15(isa[3])
    );

    tsp_xcvr_model xcvr
    (
        .clock(clock),
        .arst_n(arst_n),
        .dev_out(p_out),
        .dev_oe(p_oe),
        .ext_val(ext_val),
        .ext_en(ext_en),
        .pin_lvl(p_lvl)
    );

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input tsp_byte_t got, input tsp_byte_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input tsp_byte_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd_chk(input logic [7:0] a, input tsp_byte_t e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
        chk_byte(rdv, e);
    endtask

    task automatic setin(input logic card, input logic [4:0] s,
                         input logic [3:0] ev, input logic [3:0] en);
        @(posedge clock);
        bus_mode_card <= card;
        tx_active <= s[4];
        tx_timing_active <= s[3];
        ramp_timing_first <= s[2];
        tx_serial_data <= s[1];
        diversity_antenna_choice <= s[0];
        ext_val <= ev;
        ext_en <= en;
    endtask

    // Cause to flop, pin to level sampler, with two spare.
    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        results();
    end

    initial
    begin
        logic [5:0] v;
        logic [3:0] ee;
        logic [3:0] eo;
        logic [3:0] el;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        wr(8'h07, 8'hff);
        for (int a = 0; a < 8; a++)
            rd_chk(a[7:0], (a == 3) ? 8'h01 : 8'h00);
        rd_chk(8'hff, 8'h00);
        for (int i = 0; i < 32; i++)
        begin
            v = i[5:0];
            wr(8'h00, {3'h0, v[2], v[3], 3'h0});
            wr(8'h01, {v[1], 7'h00});
            setin(1'b1, {v[4], 3'h0, v[0]}, 4'h0, 4'h8);
            settle();
            chk_bit(antenna_select_out,
                    v[4] ? 1'b0 : (v[1] ? v[0] : v[3] & v[2]));
            chk_bit(p_out[0], v[3] ? v[2] : v[0]);
        end
        for (int m = 0; m < 2; m++)
        begin
            for (int i = 0; i < 64; i++)
            begin
                v = i[5:0];
                ee = {v[4] ^ v[1], ~v[3] | v[0], ~v[5] | ~v[2] | v[3],
                      ~v[4] | v[1]};
                ee = (m == 0) ? 4'h0 : ee;
                eo[0] = v[4] ? v[2] : (v[5] ? v[3] : v[1]);
                eo[1] = !v[5] ? v[1] : (!v[2] ? v[4] | v[0] : v[1]);
                eo[2] = v[3] ? v[0] ^ v[5] : ~v[2];
                eo[3] = v[3];
                el = (ee & eo) | (~ee & ~v[3:0]);
                wr(8'h05, {v[4], v[3], v[2], 5'h00});
                wr(8'h04, {v[1], v[0], v[3], 5'h00});
                wr(8'h03, {5'h00, v[1], v[2], v[0] ^ v[5]});
                wr(8'h02, {3'h0, v[3], v[5], 2'h0, v[4]});
                wr(8'h06, {1'h0, v[4] ^ v[1], 6'h00});
                wr(8'h00, {3'h0, v[3], v[5], 3'h0});
                wr(8'h01, 8'h00);
                setin(m[0], {1'h0, v[1], v[0], v[2], v[1]}, ~v[3:0], ~ee);
                settle();
                for (int k = 0; k < 4; k++)
                begin
                    chk_bit(p_oe[k], ee[k]);
                    if (ee[k])
                        chk_bit(p_out[k], eo[k]);
                    chk_bit(isa[k], el[k]);
                end
                rd_chk(8'h03,
                       {5'h00, el[1], el[0], el[2]});
                rd_chk(8'h02, {3'h0, el[3], v[5], 2'h0, v[4]});
                rd_chk(8'h00, {2'h0, v[3], 1'h0, v[5], 3'h0});
            end
        end
        results();
    end
endmodule
